// ### hdl/lpm_pkg.sv
// Constants and types for the low-power mode controller
//
// Operation
// - In Sleep only the CPU clock stops, peripherals keep running and any peripheral interrupt or event wakes the core.
// - In Stop every core-domain clock halts and the PLL, internal RC and crystal oscillators are disabled while state is kept.
// - In Stop the regulator runs as main or low-power regulator, each in normal (default) or under-drive operation.
// - Any external event line (16 pins, supply detector, RTC events, USB wakeup, low-power timer) wakes the device from Stop.
// - In Standby the internal regulator, PLL and both oscillators are switched off so the core domain loses power.
// - After Standby entry SRAM and registers count as lost, except backup registers and backup SRAM when retention is on;
//   here backup memory is kept even with RET clear, and interrupt status also stays.
// - Standby is left on external reset pin, watchdog reset, either edge on one of 6 wake pins, or any RTC event.
// - Every RTC event can raise an interrupt and wake the device from any low-power mode.
// - The 4 Kbyte backup memory accepts processor accesses only, guards against unwanted writes and keeps its data; only 2 Kbyte of it is mapped.
package lpm_pkg;
	// ==========================================
	// Register map
	localparam logic [11:0] LPM_CTRL_OFF = 12'h000;
	localparam logic [11:0] LPM_STAT_OFF = 12'h004;
	localparam logic [11:0] LPM_IRQ_STAT_OFF = 12'h008;
	localparam logic [11:0] LPM_IRQ_MASK_OFF = 12'h00c;
	localparam logic [11:0] LPM_BKP_KEY_OFF = 12'h010;
	localparam logic [11:0] LPM_BKP_BASE = 12'h800;
	localparam int LPM_BKP_WORDS = 1024;
	localparam logic [31:0] LPM_BKP_KEY = 32'h0000a5c3;
	// Control fields
	localparam int LPM_CTRL_REQ_LSB = 0;
	localparam int LPM_CTRL_LPR_BIT = 2;
	localparam int LPM_CTRL_UD_BIT = 3;
	localparam int LPM_CTRL_RET_BIT = 4;
	localparam int LPM_CTRL_GO_BIT = 8;
	localparam logic [31:0] LPM_CTRL_RST = 32'h00000000;
	// Interrupt status bits
	localparam int LPM_IRQ_EXT = 0;
	localparam int LPM_IRQ_RTC = 1;
	localparam int LPM_IRQ_WAKE = 2;
	localparam int LPM_IRQ_REFUSED = 3;
	localparam int LPM_IRQ_W = 4;
	// Requested mode codes
	localparam logic [1:0] LPM_REQ_SLEEP = 2'h1;
	localparam logic [1:0] LPM_REQ_STOP = 2'h2;
	localparam logic [1:0] LPM_REQ_STANDBY = 2'h3;
	localparam int LPM_EXT_PINS = 16;
	localparam int LPM_WAKE_PINS = 6;
	localparam int LPM_RTC_EV = 4;
	typedef enum logic [3:0] {
		LPM_RUN = 4'b0001,
		LPM_SLEEP = 4'b0010,
		LPM_STOP = 4'b0100,
		LPM_STANDBY = 4'b1000
	} lpm_state_t;
endpackage

// ### hdl/lpm_ctrl.sv
// Low-power mode controller with APB registers and backup memory
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pprot_priv,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [lpm_pkg::LPM_EXT_PINS-1:0] external_event_lines,
	input wire logic supply_level_detector_output,
	input wire logic [lpm_pkg::LPM_RTC_EV-1:0] rtc_events,
	input wire logic usb_wakeup,
	input wire logic low_power_timer,
	input wire logic periph_irq,
	input wire logic [lpm_pkg::LPM_WAKE_PINS-1:0] wake_pin,
	input wire logic external_reset_pin_n,
	input wire logic independent_watchdog_rst,
	input wire logic regulator_bypassed,
	output logic cpu_clk_en,
	output logic core_clk_en,
	output logic pll_en,
	output logic internal_rc_oscillator_en,
	output logic external_crystal_oscillator_en,
	output logic main_regulator_en,
	output logic low_power_regulator_en,
	output logic under_drive_en,
	output logic core_power_en,
	output logic core_reset_req,
	output logic irq
);
	import lpm_pkg::*;

	// ==========================================
	// State and registers
	lpm_state_t state_ff;
	lpm_state_t nxt_state;
	logic [31:0] ctrl_ff;
	logic [31:0] nxt_ctrl;
	logic [LPM_IRQ_W-1:0] irq_stat_ff;
	logic [LPM_IRQ_W-1:0] nxt_irq_stat;
	logic [LPM_IRQ_W-1:0] irq_mask_ff;
	logic [LPM_IRQ_W-1:0] nxt_irq_mask;
	logic bkp_unlock_ff;
	logic nxt_bkp_unlock;
	logic [LPM_WAKE_PINS-1:0] wake_pin_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic rd_done_ff;
	logic nxt_rd_done;
	logic [31:0] bkp_mem [LPM_BKP_WORDS];
	logic core_reset_ff;
	logic nxt_core_reset;

	// ==========================================
	// Helpers
	// Word decode shared by every register select except the backup memory window
	function automatic logic f_hit(input logic [11:0] addr, input logic [11:0] off);
		return addr == off;
	endfunction

	// Clocks and oscillators run only outside Stop and Standby
	function automatic logic f_clocks_on(input lpm_state_t st);
		return !(st == LPM_STOP || st == LPM_STANDBY);
	endfunction

	// Mode code 0 is not a mode, so it keeps the core running
	function automatic lpm_state_t f_req_state(input logic [1:0] mode);
		lpm_state_t st;
		unique case (mode)
			LPM_REQ_SLEEP: st = LPM_SLEEP;
			LPM_REQ_STOP: st = LPM_STOP;
			LPM_REQ_STANDBY: st = LPM_STANDBY;
			default: st = LPM_RUN;
		endcase
		return st;
	endfunction

	// ==========================================
	// Decode
	wire access = psel && penable;
	// Reads take one wait state so read data leaves a flip-flop while pready is high
	wire rd_cap = access && !pwrite && !rd_done_ff;
	assign pready = pwrite || rd_done_ff;
	wire xfer = access && pready;
	wire wr = xfer && pwrite;
	wire rd = xfer && !pwrite;
	wire hit_ctrl = f_hit(paddr, LPM_CTRL_OFF);
	wire hit_stat = f_hit(paddr, LPM_STAT_OFF);
	wire hit_istat = f_hit(paddr, LPM_IRQ_STAT_OFF);
	wire hit_imask = f_hit(paddr, LPM_IRQ_MASK_OFF);
	wire hit_key = f_hit(paddr, LPM_BKP_KEY_OFF);
	wire hit_bkp = paddr[11] && (paddr[1:0] == 2'h0);
	wire [9:0] bkp_idx = paddr[11:2] - 10'(LPM_BKP_BASE[11:2]);
	wire mapped = hit_ctrl || hit_stat || hit_istat || hit_imask || hit_key || hit_bkp;
	// Backup memory answers only privileged processor accesses
	wire bkp_ok = hit_bkp && pprot_priv;
	// Writes need the unlock key first, so a stray store cannot corrupt it
	wire bkp_wr = wr && bkp_ok && bkp_unlock_ff;
	wire bkp_err = hit_bkp && (!pprot_priv || (pwrite && !bkp_unlock_ff));
	assign pslverr = xfer && (!mapped || bkp_err);

	// ==========================================
	// Mode request and wake sources
	wire go = wr && hit_ctrl && pwdata[LPM_CTRL_GO_BIT];
	wire [1:0] go_mode = pwdata[LPM_CTRL_REQ_LSB +: 2];
	// Bypassed regulator cannot power-gate the core, so Standby is refused
	wire standby_refused = go && (go_mode == LPM_REQ_STANDBY) && regulator_bypassed;
	wire rtc_any = |rtc_events;
	wire ext_any = (|external_event_lines) || supply_level_detector_output || rtc_any
		|| usb_wakeup || low_power_timer;
	// Pin history resets to the idle low level, so no false edge follows reset
	wire wake_edge = |(wake_pin ^ wake_pin_ff);
	wire standby_exit = !external_reset_pin_n || independent_watchdog_rst || wake_edge || rtc_any;
	wire sleep_wake = periph_irq || ext_any;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			LPM_RUN: begin
				if (go && !standby_refused) begin
					nxt_state = f_req_state(go_mode);
				end
			end
			LPM_SLEEP: if (sleep_wake) nxt_state = LPM_RUN;
			LPM_STOP: if (ext_any) nxt_state = LPM_RUN;
			LPM_STANDBY: if (standby_exit) nxt_state = LPM_RUN;
			default: nxt_state = LPM_RUN;
		endcase
	end

	// ==========================================
	// Interrupts: set wins over read-clear
	wire exit_to_run = (state_ff != LPM_RUN) && (nxt_state == LPM_RUN);
	wire [LPM_IRQ_W-1:0] irq_set = {standby_refused, exit_to_run, rtc_any, ext_any};
	wire istat_rd = rd && hit_istat;
	// Clear only what the read reported, so an event in the wait state survives
	wire [LPM_IRQ_W-1:0] irq_clr = istat_rd ? prdata_ff[LPM_IRQ_W-1:0] : '0;
	assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ==========================================
	// Read data
	wire [31:0] stat_word = {26'h0, regulator_bypassed, bkp_unlock_ff, state_ff};
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (hit_ctrl) rd_mux = ctrl_ff;
		if (hit_stat) rd_mux = stat_word;
		if (hit_istat) rd_mux = {28'h0, irq_stat_ff};
		if (hit_imask) rd_mux = {28'h0, irq_mask_ff};
		if (bkp_ok) rd_mux = bkp_mem[bkp_idx];
	end
	assign prdata = prdata_ff;
	assign nxt_prdata = rd_cap ? rd_mux : prdata_ff;
	assign nxt_rd_done = rd_cap;

	// ==========================================
	// Next register values
	// Core-domain state is lost on Standby exit: reset control (keeping RET), mask and unlock; backup and interrupt status stay
	assign nxt_core_reset = (state_ff == LPM_STANDBY) && (nxt_state == LPM_RUN);

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr && hit_ctrl) nxt_ctrl = {27'h0, pwdata[4:0]};
		if (core_reset_ff) nxt_ctrl = {27'h0, ctrl_ff[LPM_CTRL_RET_BIT], 4'h0};
	end

	always_comb begin
		nxt_irq_mask = irq_mask_ff;
		if (wr && hit_imask) nxt_irq_mask = pwdata[LPM_IRQ_W-1:0];
		if (core_reset_ff) nxt_irq_mask = '0;
	end

	always_comb begin
		nxt_bkp_unlock = bkp_unlock_ff;
		if (wr && hit_key) nxt_bkp_unlock = (pwdata == LPM_BKP_KEY);
		if (core_reset_ff) nxt_bkp_unlock = 1'b0;
	end

	// ==========================================
	// Mode state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= LPM_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================
	// Control word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= LPM_CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ==========================================
	// Interrupt status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	// ==========================================
	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= '0;
		end else begin
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	// ==========================================
	// Backup unlock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bkp_unlock_ff <= 1'b0;
		end else begin
			bkp_unlock_ff <= nxt_bkp_unlock;
		end
	end

	// ==========================================
	// Wake pin history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_pin_ff <= '0;
		end else begin
			wake_pin_ff <= wake_pin;
		end
	end

	// ==========================================
	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	// ==========================================
	// Read wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_done_ff <= 1'b0;
		end else begin
			rd_done_ff <= nxt_rd_done;
		end
	end

	// ==========================================
	// Core reset pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_ff <= 1'b0;
		end else begin
			core_reset_ff <= nxt_core_reset;
		end
	end

	// Backup memory has no reset, so it survives Standby
	always_ff @(posedge pclk) begin
		if (bkp_wr) bkp_mem[bkp_idx] <= pwdata;
	end

	// ==========================================
	// Power and clock fabric
	wire in_stop = state_ff == LPM_STOP;
	wire in_stby = state_ff == LPM_STANDBY;
	assign cpu_clk_en = state_ff == LPM_RUN;
	assign core_clk_en = f_clocks_on(state_ff);
	assign pll_en = f_clocks_on(state_ff);
	assign internal_rc_oscillator_en = f_clocks_on(state_ff);
	assign external_crystal_oscillator_en = f_clocks_on(state_ff);
	// Main regulator hands over to the low-power one only while stopped
	assign main_regulator_en = !in_stby && !(in_stop && ctrl_ff[LPM_CTRL_LPR_BIT]);
	assign low_power_regulator_en = in_stop && ctrl_ff[LPM_CTRL_LPR_BIT];
	// Under-drive only means something while stopped
	assign under_drive_en = in_stop && ctrl_ff[LPM_CTRL_UD_BIT];
	assign core_power_en = !in_stby;
	assign core_reset_req = core_reset_ff;

endmodule
`default_nettype wire

// ### testbench/lpm_ctrl_assertions.sv
// Port checker for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [lpm_pkg::LPM_EXT_PINS-1:0] external_event_lines,
	input wire logic [lpm_pkg::LPM_RTC_EV-1:0] rtc_events,
	input wire logic periph_irq,
	input wire logic [lpm_pkg::LPM_WAKE_PINS-1:0] wake_pin,
	input wire logic external_reset_pin_n,
	input wire logic independent_watchdog_rst,
	input wire logic regulator_bypassed,
	input wire logic cpu_clk_en,
	input wire logic core_clk_en,
	input wire logic pll_en,
	input wire logic internal_rc_oscillator_en,
	input wire logic external_crystal_oscillator_en,
	input wire logic main_regulator_en,
	input wire logic low_power_regulator_en,
	input wire logic under_drive_en,
	input wire logic core_power_en,
	input wire logic core_reset_req
);
	import lpm_pkg::*;
	// ==========
	// Mode entries only count from run, where go is honoured
	wire logic go = psel && penable && pwrite && paddr == LPM_CTRL_OFF && pwdata[LPM_CTRL_GO_BIT] && cpu_clk_en;
	wire logic [1:0] md = pwdata[1:0];
	wire logic osc_off = !pll_en && !internal_rc_oscillator_en && !external_crystal_oscillator_en;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_sleep_entry: assert property (go && md == LPM_REQ_SLEEP |=> !cpu_clk_en && core_clk_en && pll_en)
		else $error("sleep entry wrong");
	a_sleep_wake: assert property (!cpu_clk_en && core_clk_en && periph_irq |=> cpu_clk_en)
		else $error("sleep not left");
	a_stop_clocks: assert property (go && md == LPM_REQ_STOP |=> !core_clk_en && osc_off && core_power_en)
		else $error("stop clocks wrong");
	a_stop_reg: assert property (go && md == LPM_REQ_STOP |=> low_power_regulator_en == $past(pwdata[2])
		&& main_regulator_en != low_power_regulator_en && under_drive_en == $past(pwdata[3]))
		else $error("stop regulator wrong");
	a_stop_wake: assert property (!core_clk_en && core_power_en && |external_event_lines
		|=> cpu_clk_en && !core_reset_req ##1 !core_reset_req)
		else $error("stop wake wrong");
	a_stby_off: assert property (go && md == LPM_REQ_STANDBY && !regulator_bypassed
		|=> !core_power_en && !main_regulator_en && !low_power_regulator_en && osc_off)
		else $error("standby power left on");
	a_bypass_keep: assert property (go && md == LPM_REQ_STANDBY && regulator_bypassed |=> cpu_clk_en && core_power_en)
		else $error("standby taken while bypassed");
	a_stby_exit: assert property (!core_power_en && (!external_reset_pin_n || independent_watchdog_rst || |rtc_events
		|| $changed(wake_pin)) |=> core_power_en ##[0:1] core_reset_req)
		else $error("standby exit wrong");
endmodule
bind lpm_ctrl lpm_chk u_chk (.*);
`default_nettype wire

// ### testbench/lpm_wake_src.sv
// Wake-source model at the controller's far side
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_src (
	input wire logic fire,
	input wire logic [2:0] sel,
	output wire logic [15:0] external_event_lines,
	output wire logic periph_irq,
	output wire logic [3:0] rtc_events,
	output wire logic external_reset_pin_n,
	output wire logic independent_watchdog_rst,
	output wire logic [5:0] wake_pin
);
	// ==========
	// One pulse per fire; a wake pin pulse gives both edges
	assign external_event_lines = {10'h0, fire && sel == 3'h0, 5'h0};
	assign periph_irq = fire && sel == 3'h1;
	assign rtc_events = {fire && sel == 3'h2, 3'h0};
	assign external_reset_pin_n = !(fire && sel == 3'h3);
	assign independent_watchdog_rst = fire && sel == 3'h4;
	assign wake_pin = {3'h0, fire && sel == 3'h5, 2'h0};
endmodule
`default_nettype wire

// ### testbench/tb_low_power_mode_controller.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_low_power_mode_controller;
	import lpm_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0, saw = 1'b0, err, i0;
	logic regulator_bypassed = 1'b0, pprot_priv = 1'b1, supply_level_detector_output = 1'b0;
	logic usb_wakeup = 1'b0, low_power_timer = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [2:0] sel = 3'h0;
	int n_fail = 0, n_checks = 0;
	wire logic [31:0] prdata;
	wire logic [15:0] external_event_lines;
	wire logic [3:0] rtc_events;
	wire logic [5:0] wake_pin;
	wire logic pready, pslverr, periph_irq, external_reset_pin_n, independent_watchdog_rst, cpu_clk_en, core_clk_en;
	wire logic pll_en, internal_rc_oscillator_en, external_crystal_oscillator_en, main_regulator_en;
	wire logic low_power_regulator_en, under_drive_en, core_power_en, core_reset_req, irq;
	lpm_ctrl uut (.*);
	lpm_wake_src src (.*);
	always #10 pclk = ~pclk;
	always @(posedge pclk) if (core_reset_req === 1'b1) saw <= 1'b1;
	// ==========
	// Tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wake(input logic [2:0] k);
		@(posedge pclk);
		sel <= k;
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
	endtask
	task automatic t_regs;
		apb(0, LPM_STAT_OFF, 0);
		`CHK("status", 32'h1, rd)
		apb(0, 12'h020, 0);
		`CHK("unmapped", 1'b1, err)
		apb(1, LPM_BKP_BASE, 32'h5a); // Still locked
		`CHK("locked", 1'b1, err)
		@(posedge pclk) pprot_priv <= 1'b0;
		apb(1, LPM_BKP_KEY_OFF, LPM_BKP_KEY);
		apb(1, LPM_BKP_BASE, 32'h5a);
		`CHK("unpriv", 1'b1, err)
		@(posedge pclk) pprot_priv <= 1'b1;
		apb(1, LPM_BKP_BASE, 32'h5a);
		apb(0, LPM_BKP_BASE, 0);
		`CHK("bkp", 32'h5a, rd)
	endtask
	task automatic t_sleep_irq;
		apb(0, LPM_IRQ_STAT_OFF, 0);
		apb(1, LPM_CTRL_OFF, 32'h101);
		`CHK("sleep", 2'h1, {cpu_clk_en, core_clk_en})
		wake(0);
		i0 = irq;
		apb(1, LPM_IRQ_MASK_OFF, 32'hf);
		apb(1, LPM_CTRL_OFF, 32'h101);
		wake(1);
		`CHK("woke", 1'b1, cpu_clk_en)
		`CHK("mask", 1'b1, irq ^ i0)
		apb(0, LPM_IRQ_STAT_OFF, 0);
		`CHK("ist", 3'h5, rd[2:0] & 3'h5)
		`CHK("irqclr", 1'b0, irq)
		apb(1, LPM_IRQ_MASK_OFF, 0);
	endtask
	task automatic t_stop;
		for (int k = 0; k < 3; k += 2) begin
			saw = 1'b0;
			apb(1, LPM_CTRL_OFF, k == 0 ? 32'h11e : 32'h112);
			`CHK("clk", 4'h0, {core_clk_en, pll_en, internal_rc_oscillator_en, external_crystal_oscillator_en})
			`CHK("reg", k == 0 ? 3'h3 : 3'h4, {main_regulator_en, low_power_regulator_en, under_drive_en})
			wake(k[2:0]);
			`CHK("resume", 2'h2, {cpu_clk_en, saw})
		end
		apb(1, LPM_CTRL_OFF, 32'h102);
		@(posedge pclk) low_power_timer <= 1'b1;
		@(posedge pclk) low_power_timer <= 1'b0;
		#1 `CHK("lptim", 1'b1, cpu_clk_en)
	endtask
	task automatic t_standby;
		@(posedge pclk) regulator_bypassed <= 1'b1;
		apb(1, LPM_CTRL_OFF, 32'h113);
		`CHK("bypass", 2'h3, {cpu_clk_en, core_power_en})
		apb(0, LPM_IRQ_STAT_OFF, 0);
		`CHK("refused", 1'b1, rd[3])
		@(posedge pclk) regulator_bypassed <= 1'b0;
		for (int k = 2; k < 6; k++) begin
			saw = 1'b0;
			apb(1, LPM_CTRL_OFF, 32'h113);
			`CHK("off", 3'h0, {core_power_en, main_regulator_en, pll_en})
			wake(k[2:0]);
			`CHK("exit", 2'h3, {core_power_en, saw})
		end
		apb(0, LPM_BKP_BASE, 0);
		`CHK("kept", 32'h5a, rd)
		apb(1, LPM_BKP_BASE, 32'h0);
		`CHK("relock", 1'b1, err)
	endtask
	task give_verdict;
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ==========
	// Main sequence and watchdog
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_sleep_irq();
		t_stop();
		t_standby();
		give_verdict();
	end
	initial begin
		#100000;
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
